// [core/pbg_port_b.sv]
// Eight-bit port with direction, latch, pull-ups and change detection
//
// Contract
// - Eight pins, each with own direction bit
// - Direction one floats the pin as input
// - Direction zero drives the latch bit
// - Latch register reads back latch, not pins
// - Shared active-low bit enables all pull-ups
// - Output pins never get a pull-up
// - Pull-ups off after reset
// - After reset pins are inputs, digital except pins two, three per strap
// - Pins two, three analog when strap clear
// - Analog mode blocks digital input only
// - Six pins can carry PWM outputs
// - Detector watches four pins, skips outputs
// - Compare against value caught at access
// - ORed mismatches set the change flag
// - Change flag can wake the device
// - Port access ends mismatch, software clears flag
// - Flag keeps setting while mismatch lasts
// - Flag sets regardless of its enable
`timescale 1ns/1ps
module pbg_port_b (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  // AXI4-Lite slave
  input  wire logic [pbg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output wire logic                      s_axi_awready,
  input  wire logic [pbg_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output wire logic                      s_axi_wready,
  output wire logic [1:0]                s_axi_bresp,
  output wire logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [pbg_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output wire logic                      s_axi_arready,
  output wire logic [pbg_pkg::DATA_W-1:0] s_axi_rdata,
  output wire logic [1:0]                s_axi_rresp,
  output wire logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Port pins
  input  wire logic [7:0]                pinIn,
  output wire logic [7:0]                pinOut,
  output wire logic [7:0]                pinOe,
  output wire logic [7:0]                pullupEn,
  // Shared PWM channels, one per pin position
  input  wire logic [7:0]                pwmIn,
  // Neighbouring port
  input  wire logic [1:0]                portAPinIn,
  input  wire logic [1:0]                portADir,
  input  wire logic                      portAAccess,
  // Configuration and system
  input  wire logic                      timerOscPlacementCfg,
  input  wire logic                      memMoveAccess,
  output wire logic                      portChangeFlag,
  output wire logic                      wakeOut
);
  // Bus handshake state
  logic        bvalid_reg;
  logic        bvalid_next;
  logic [1:0]  bresp_reg;
  logic [1:0]  bresp_next;
  logic        rvalid_reg;
  logic        rvalid_next;
  logic [1:0]  rresp_reg;
  logic [1:0]  rresp_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // Register file state
  logic [7:0]  dir_reg;
  logic [7:0]  dir_next;
  logic [7:0]  lat_reg;
  logic [7:0]  lat_next;
  logic [7:0]  ansel_reg;
  logic [7:0]  ansel_next;
  logic [7:0]  pwmSel_reg;
  logic [7:0]  pwmSel_next;
  logic        pullDisN_reg;
  logic        pullDisN_next;
  logic        flagEn_reg;
  logic        flagEn_next;
  logic        flag_reg;
  logic        flag_next;
  logic        strapPending_reg;
  logic        strapPending_next;

  // Pin side state
  logic [7:0]  pinOut_reg;
  logic [7:0]  pinOut_next;
  logic [7:0]  pinOe_reg;
  logic [7:0]  pinOe_next;
  logic [7:0]  pull_reg;
  logic [7:0]  pull_next;
  logic        wake_reg;
  logic        wake_next;

  // Decode helpers
  logic        wrTake;
  logic        rdTake;
  logic        wrLow;
  logic [7:0]  wByte;
  logic [7:0]  digIn;
  logic        anyMismatch;

  pbg_chg_if chg ();

  // Write address and data are taken together, one write in flight
  assign wrTake = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
  assign rdTake = s_axi_arvalid & ~rvalid_reg;
  assign wrLow  = wrTake & s_axi_wstrb[0];
  assign wByte  = s_axi_wdata[7:0];
  assign s_axi_awready = wrTake;
  assign s_axi_wready  = wrTake;
  assign s_axi_arready = rdTake;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  // Analog selection kills the digital input path only
  assign digIn = pinIn & ~ansel_reg;

  // Write response next state; unmapped offsets answer with an error
  always_comb begin
    bvalid_next = bvalid_reg;
    bresp_next  = bresp_reg;
    if (wrTake) begin
      bvalid_next = 1'b1;
      unique case (s_axi_awaddr)
        pbg_pkg::OFF_PIN, pbg_pkg::OFF_DIR, pbg_pkg::OFF_LAT, pbg_pkg::OFF_INTC,
        pbg_pkg::OFF_INTC2, pbg_pkg::OFF_ANSEL, pbg_pkg::OFF_PWMSEL: begin
          bresp_next = pbg_pkg::RESP_OKAY;
        end
        default: begin
          bresp_next = pbg_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  // Read data next state; data is captured at the address handshake
  always_comb begin
    rvalid_next = rvalid_reg;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    if (rdTake) begin
      rvalid_next = 1'b1;
      rresp_next  = pbg_pkg::RESP_OKAY;
      rdata_next  = 32'h0;
      unique case (s_axi_araddr)
        pbg_pkg::OFF_PIN:    rdata_next[7:0] = digIn;
        pbg_pkg::OFF_DIR:    rdata_next[7:0] = dir_reg;
        pbg_pkg::OFF_LAT:    rdata_next[7:0] = lat_reg;
        pbg_pkg::OFF_INTC: begin
          rdata_next[pbg_pkg::FLAG_BIT]   = flag_reg;
          rdata_next[pbg_pkg::ENABLE_BIT] = flagEn_reg;
        end
        pbg_pkg::OFF_INTC2:  rdata_next[pbg_pkg::PULLDIS_BIT] = pullDisN_reg;
        pbg_pkg::OFF_ANSEL:  rdata_next[7:0] = ansel_reg;
        pbg_pkg::OFF_PWMSEL: rdata_next[7:0] = pwmSel_reg;
        default:             rresp_next = pbg_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= pbg_pkg::RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg  <= pbg_pkg::RESP_OKAY;
      rdata_reg  <= 32'h0;
    end else begin
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg  <= rresp_next;
      rdata_reg  <= rdata_next;
    end
  end

  // Register file next state; the strap is caught one cycle after reset
  always_comb begin
    dir_next          = dir_reg;
    lat_next          = lat_reg;
    ansel_next        = ansel_reg;
    pwmSel_next       = pwmSel_reg;
    pullDisN_next     = pullDisN_reg;
    flagEn_next       = flagEn_reg;
    strapPending_next = 1'b0;
    if (strapPending_reg) begin
      ansel_next[pbg_pkg::OSC_LO_PIN] = ~timerOscPlacementCfg;
      ansel_next[pbg_pkg::OSC_HI_PIN] = ~timerOscPlacementCfg;
    end
    if (wrLow) begin
      unique case (s_axi_awaddr)
        pbg_pkg::OFF_PIN:    lat_next = wByte;
        pbg_pkg::OFF_DIR:    dir_next = wByte;
        pbg_pkg::OFF_LAT:    lat_next = wByte;
        pbg_pkg::OFF_INTC:   flagEn_next = wByte[pbg_pkg::ENABLE_BIT];
        pbg_pkg::OFF_INTC2:  pullDisN_next = wByte[pbg_pkg::PULLDIS_BIT];
        pbg_pkg::OFF_ANSEL:  ansel_next = wByte;
        pbg_pkg::OFF_PWMSEL: pwmSel_next = wByte & pbg_pkg::PWM_PINS;
        default:             dir_next = dir_reg;
      endcase
    end
  end

  // Reset leaves all pins as floating inputs with pull-ups off
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dir_reg          <= pbg_pkg::DIR_RST;
      lat_reg          <= pbg_pkg::LAT_RST;
      ansel_reg        <= pbg_pkg::ANSEL_RST;
      pwmSel_reg       <= pbg_pkg::PWMSEL_RST;
      pullDisN_reg     <= pbg_pkg::PULLDIS_RST;
      flagEn_reg       <= 1'b0;
      strapPending_reg <= 1'b1;
    end else begin
      dir_reg          <= dir_next;
      lat_reg          <= lat_next;
      ansel_reg        <= ansel_next;
      pwmSel_reg       <= pwmSel_next;
      pullDisN_reg     <= pullDisN_next;
      flagEn_reg       <= flagEn_next;
      strapPending_reg <= strapPending_next;
    end
  end

  // Detector hookup; a memory-to-memory move does not refresh the reference
  assign chg.mon    = {portAPinIn, digIn[pbg_pkg::OSC_HI_PIN:pbg_pkg::OSC_LO_PIN]};
  assign chg.inMask = {portADir, dir_reg[pbg_pkg::OSC_HI_PIN:pbg_pkg::OSC_LO_PIN]};
  assign chg.refresh = portAAccess | (~memMoveAccess &
                       ((rdTake & (s_axi_araddr == pbg_pkg::OFF_PIN)) |
                        (wrTake & (s_axi_awaddr == pbg_pkg::OFF_PIN))));
  assign anyMismatch = |chg.mismatch;

  pbg_change_detect u_detect (
    .ref_clk (ref_clk),
    .rst     (rst),
    .chg     (chg)
  );

  // Flag next state; a live mismatch beats a software clear
  always_comb begin
    flag_next = flag_reg;
    if (wrLow && s_axi_awaddr == pbg_pkg::OFF_INTC) begin
      flag_next = wByte[pbg_pkg::FLAG_BIT];
    end
    if (anyMismatch) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // Pin drivers; PWM overrides latch and direction on its pins
  always_comb begin
    pinOe_next  = ~dir_reg | pwmSel_reg;
    pinOut_next = (lat_reg & ~pwmSel_reg) | (pwmIn & pwmSel_reg);
    pull_next   = {8{~pullDisN_reg}} & ~pinOe_next;
    wake_next   = flag_reg & flagEn_reg;
  end

  // Pins are registered so they change cleanly one cycle after control
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pinOe_reg  <= 8'h00;
      pinOut_reg <= 8'h00;
      pull_reg   <= 8'h00;
      wake_reg   <= 1'b0;
    end else begin
      pinOe_reg  <= pinOe_next;
      pinOut_reg <= pinOut_next;
      pull_reg   <= pull_next;
      wake_reg   <= wake_next;
    end
  end

  assign pinOe          = pinOe_reg;
  assign pinOut         = pinOut_reg;
  assign pullupEn       = pull_reg;
  assign wakeOut        = wake_reg;
  assign portChangeFlag = flag_reg;

  // Checks on the port behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_dir_write;
    wrLow && s_axi_awaddr == pbg_pkg::OFF_DIR && pwmSel_reg == 8'h00;
  endsequence
  sequence s_lat_write;
    wrLow && s_axi_awaddr == pbg_pkg::OFF_LAT && pwmSel_reg == 8'h00;
  endsequence

  a_dir_to_oe: assert property (
    s_dir_write ##1 (pwmSel_reg == 8'h00) |=> pinOe == ~$past(wByte, 2))
    else $error("pin enable does not follow direction write");
  a_latch_to_pin: assert property (
    s_lat_write ##1 (pwmSel_reg == 8'h00) |=> pinOut == $past(wByte, 2))
    else $error("pin value does not follow latch write");
  a_latch_readback: assert property (
    rdTake && s_axi_araddr == pbg_pkg::OFF_LAT |=> s_axi_rdata[7:0] == $past(lat_reg))
    else $error("latch read returned something other than latch");
  a_pull_rules: assert property (
    (pullupEn != 8'h00) |-> !$past(pullDisN_reg) && (pullupEn & pinOe) == 8'h00)
    else $error("pull-up on output or while disabled");
  a_reset_state: assert property (disable iff (1'b0)
    $past(rst) |-> pullupEn == 8'h00 && pinOe == 8'h00 && dir_reg == 8'hff)
    else $error("pins not inputs without pull-ups after reset");
  a_strap_analog: assert property (disable iff (1'b0)
    !rst && $past(rst) |=> !rst |-> ansel_reg[3:2] == {2{~$past(timerOscPlacementCfg)}})
    else $error("analog default does not follow strap");
  a_analog_read: assert property (
    rdTake && s_axi_araddr == pbg_pkg::OFF_PIN && ansel_reg[2] |=> s_axi_rdata[2] == 1'b0)
    else $error("analog pin read as digital");
  a_flag_sets: assert property (
    anyMismatch |=> flag_reg)
    else $error("mismatch did not set change flag");
  a_wake_path: assert property (
    anyMismatch && flagEn_reg && !(wrLow && s_axi_awaddr == pbg_pkg::OFF_INTC) |=> ##1 wakeOut)
    else $error("change did not raise wake");
  a_flag_clear: assert property (
    wrLow && s_axi_awaddr == pbg_pkg::OFF_INTC && !wByte[0] && !anyMismatch |=> !flag_reg)
    else $error("software clear of change flag lost");
endmodule

// [core/pbg_pkg.sv]
// Shared constants for the port B pin block with change detection
package pbg_pkg;
  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_PIN    = 8'h00;
  localparam logic [7:0] OFF_DIR    = 8'h04;
  localparam logic [7:0] OFF_LAT    = 8'h08;
  localparam logic [7:0] OFF_INTC   = 8'h10;
  localparam logic [7:0] OFF_INTC2  = 8'h14;
  localparam logic [7:0] OFF_ANSEL  = 8'h18;
  localparam logic [7:0] OFF_PWMSEL = 8'h1c;

  // Field positions
  localparam int FLAG_BIT    = 0;
  localparam int ENABLE_BIT  = 3;
  localparam int PULLDIS_BIT = 7;
  localparam int OSC_LO_PIN  = 2;
  localparam int OSC_HI_PIN  = 3;

  // Reset values
  localparam logic [7:0] DIR_RST    = 8'hff;
  localparam logic [7:0] LAT_RST    = 8'h00;
  localparam logic [7:0] ANSEL_RST  = 8'h0c;
  localparam logic [7:0] PWMSEL_RST = 8'h00;
  localparam logic       PULLDIS_RST = 1'b1;

  // Pins that may carry a PWM channel
  localparam logic [7:0] PWM_PINS = 8'hf3;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [core/pbg_chg_if.sv]
// Signals between the port block and its change detector
`timescale 1ns/1ps
interface pbg_chg_if;
  logic [3:0] mon;
  logic [3:0] inMask;
  logic       refresh;
  logic [3:0] mismatch;

  modport top (output mon, output inMask, output refresh, input mismatch);
  modport det (input mon, input inMask, input refresh, output mismatch);
endinterface

// [core/pbg_change_detect.sv]
// Reference latch and per-pin mismatch for the change detector
`timescale 1ns/1ps
module pbg_change_detect (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Detector link
  pbg_chg_if.det   chg
);
  logic [3:0] ref_reg;
  logic [3:0] ref_next;

  // Reference is refreshed by every qualifying port access
  always_comb begin
    ref_next = chg.refresh ? chg.mon : ref_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ref_reg <= 4'h0;
    end else begin
      ref_reg <= ref_next;
    end
  end

  // Output-configured pins never mismatch
  assign chg.mismatch = (chg.mon ^ ref_reg) & chg.inMask;

  a_ref_capture: assert property (@(posedge ref_clk) disable iff (rst)
    chg.refresh |=> ref_reg == $past(chg.mon))
    else $error("reference not captured on port access");
  a_out_excluded: assert property (@(posedge ref_clk) disable iff (rst)
    (chg.mismatch & ~chg.inMask) == 4'h0)
    else $error("output pin took part in change compare");
endmodule

// [sim/pbg_pin_model.sv]
// Pad and board model on the pin side of the port
`timescale 1ns/1ps
module pbg_pin_model (
  // Clock
  input  wire logic       ref_clk,
  // Device side
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe,
  input  wire logic [7:0] pullupEn,
  // Board side
  input  wire logic [7:0] extDrive,
  input  wire logic [7:0] extEn,
  output var  logic [7:0] pinIn
);
  logic [7:0] floatLvl = 8'h00;

  // A pad nobody holds wanders, so show a value that keeps changing
  always_ff @(posedge ref_clk) begin
    floatLvl <= ~floatLvl;
  end

  // Device driver wins, then the board, then the weak pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pinOe[i]) begin
        pinIn[i] = pinOut[i];
      end else if (extEn[i]) begin
        pinIn[i] = extDrive[i];
      end else if (pullupEn[i]) begin
        pinIn[i] = 1'b1;
      end else begin
        pinIn[i] = floatLvl[i];
      end
    end
  end
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the port B pin block
`timescale 1ns/1ps
module tb_top;
  localparam logic [1:0] OK = pbg_pkg::RESP_OKAY;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0]  pinIn, pinOut, pinOe, pullupEn;
  logic [7:0]  pwmIn = 8'h00, extDrive = 8'h00, extEn = 8'hff;
  logic [1:0]  portAPinIn = 2'b00, portADir = 2'b11;
  logic        portAAccess = 1'b0, timerOscPlacementCfg = 1'b0, memMoveAccess = 1'b0;
  logic        portChangeFlag, wakeOut;
  int          err_count = 0, total_checks = 0;
  logic [31:0] seed = 32'h397e;
  logic [33:0] readQ[$];
  logic [1:0]  respQ[$];
  logic [7:0]  latVal, extVal, pwmVal;

  pbg_port_b uut (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pinIn, .pinOut, .pinOe, .pullupEn,
    .pwmIn, .portAPinIn, .portADir, .portAAccess, .timerOscPlacementCfg, .memMoveAccess,
    .portChangeFlag, .wakeOut);
  pbg_pin_model pads (.ref_clk, .pinOut, .pinOe, .pullupEn, .extDrive, .extEn, .pinIn);

  // Clock of 100 ns period
  always #50 ref_clk = ~ref_clk;

  // Xorshift source for byte values
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus write: address and data offered together, response noted for the watcher
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    respQ.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Bus read; expected data and response go to the watcher
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    readQ.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Watcher: every completed response is matched against the oldest note
  always @(posedge ref_clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      chk({s_axi_rresp, s_axi_rdata}, readQ.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready) begin
      chk(34'(s_axi_bresp), 34'(respQ.pop_front()));
    end
  end

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under this many cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    err_count++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk(34'({pinOe, pullupEn}), 34'h0);
    rd(pbg_pkg::OFF_DIR, 32'hff, OK);
    rd(pbg_pkg::OFF_INTC2, 32'h80, OK);
    rd(pbg_pkg::OFF_ANSEL, 32'h0c, OK);
    rd(8'h20, 32'h0, pbg_pkg::RESP_SLVERR);
    // Direction, latch and pin readback
    latVal = rnd();
    extVal = rnd();
    extDrive <= extVal;
    wr(pbg_pkg::OFF_DIR, 8'h0f, OK);
    wr(pbg_pkg::OFF_PIN, latVal, OK);
    repeat (2) @(posedge ref_clk);
    chk(34'(pinOe), 34'hf0);
    chk(34'(pinOut & 8'hf0), 34'(latVal & 8'hf0));
    // A write without its low byte lane must leave the latch alone
    s_axi_wstrb <= 4'he;
    wr(pbg_pkg::OFF_LAT, ~latVal, OK);
    s_axi_wstrb <= 4'hf;
    rd(pbg_pkg::OFF_LAT, {24'h0, latVal}, OK);
    rd(pbg_pkg::OFF_PIN, {24'h0, (extVal & 8'h03) | (latVal & 8'hf0)}, OK);
    // Unmapped writes are refused; a direct latch write reaches the output pins
    wr(8'h20, 8'h5a, pbg_pkg::RESP_SLVERR);
    wr(pbg_pkg::OFF_LAT, ~latVal, OK);
    repeat (2) @(posedge ref_clk);
    chk(34'(pinOut & 8'hf0), 34'(~latVal & 8'hf0));
    // Shared pull-ups never reach output pins
    wr(pbg_pkg::OFF_INTC2, 8'h00, OK);
    repeat (2) @(posedge ref_clk);
    chk(34'(pullupEn), 34'h0f);
    // PWM takes over its six pins
    pwmVal = rnd();
    pwmIn <= pwmVal;
    wr(pbg_pkg::OFF_PWMSEL, 8'hff, OK);
    repeat (2) @(posedge ref_clk);
    chk(34'({pinOe, pullupEn}), 34'hf30c);
    chk(34'(pinOut & 8'hf3), 34'(pwmVal & 8'hf3));
    rd(pbg_pkg::OFF_PWMSEL, 32'hf3, OK);
    wr(pbg_pkg::OFF_PWMSEL, 8'h00, OK);
    // Change detector: settle, refresh, clear
    wr(pbg_pkg::OFF_ANSEL, 8'h00, OK);
    wr(pbg_pkg::OFF_DIR, 8'hff, OK);
    repeat (3) @(posedge ref_clk);
    rd(pbg_pkg::OFF_PIN, {24'h0, extVal}, OK);
    wr(pbg_pkg::OFF_INTC, 8'h00, OK);
    rd(pbg_pkg::OFF_INTC, 32'h00, OK);
    extDrive <= extVal ^ 8'h04;
    repeat (4) @(posedge ref_clk);
    chk(34'({portChangeFlag, wakeOut}), 34'h2);
    wr(pbg_pkg::OFF_INTC, 8'h09, OK);
    repeat (2) @(posedge ref_clk);
    chk(34'(wakeOut), 34'h1);
    wr(pbg_pkg::OFF_INTC, 8'h08, OK);
    rd(pbg_pkg::OFF_INTC, 32'h09, OK);
    // A memory-to-memory move of the pin register leaves the reference alone
    memMoveAccess <= 1'b1;
    rd(pbg_pkg::OFF_PIN, {24'h0, extVal ^ 8'h04}, OK);
    memMoveAccess <= 1'b0;
    wr(pbg_pkg::OFF_INTC, 8'h08, OK);
    rd(pbg_pkg::OFF_INTC, 32'h09, OK);
    rd(pbg_pkg::OFF_PIN, {24'h0, extVal ^ 8'h04}, OK);
    wr(pbg_pkg::OFF_INTC, 8'h08, OK);
    rd(pbg_pkg::OFF_INTC, 32'h08, OK);
    // Neighbour port: input pin triggers, output pin is ignored
    portAPinIn <= 2'b01;
    repeat (4) @(posedge ref_clk);
    chk(34'(portChangeFlag), 34'h1);
    portAAccess <= 1'b1;
    @(posedge ref_clk);
    portAAccess <= 1'b0;
    wr(pbg_pkg::OFF_INTC, 8'h00, OK);
    rd(pbg_pkg::OFF_INTC, 32'h00, OK);
    portADir <= 2'b01;
    portAPinIn <= 2'b11;
    repeat (4) @(posedge ref_clk);
    chk(34'(portChangeFlag), 34'h0);
    // Second reset with the oscillator strap set
    timerOscPlacementCfg <= 1'b1;
    rst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk(34'({pinOe, pullupEn}), 34'h0);
    rd(pbg_pkg::OFF_ANSEL, 32'h00, OK);
    report_and_stop();
  end
endmodule
